/* File: hiccup_overcurrent_controller.sv */
/*
 * Two-channel switching supervisor: oscillator divider, gate pulse timing, hiccup and power-good.
 * Assumes all comparator and strap inputs are synchronous to clk and analog loops sit outside.
 */
// Functional notes
// - Overcurrent flagged in a period when loop demand has reached its clamp.
// - Sixteen consecutive overcurrent periods put the channel into hiccup sleep.
// - Sleep pulls loop demand to ground and holds the gate off from its second clock onward.
// - Sleep enables the soft-start discharge sink.
// - Empty soft-start node ends sleep, releases demand and restarts soft-start.
// - No hiccup entry while soft-start is running.
// - Two quiet periods before sixteen clear the overcurrent timer.
// - After early clearing, recovery goes through the internal soft-start ramp.
// - Loop demand below light-load threshold skips the gate pulse that period.
// - Each channel drives its own power-good, high only inside regulation window.
// - External clock sets period starts; otherwise the rate setting does.
// - Minimum gate on-time is selectable through the blanking selection.
// - Single, dual and four-phase arrangements via phase setting and clock output.
// - Blanking: ground 120 ns, open 160 ns, supply 200 ns.
// - Maximum duty: ground 96 percent, open 84, supply 75.
// - Oscillator runs at twelve ticks per period; counter derives period and duty.
// - Overvoltage trip holds the gate off until the comparator clears.
`timescale 1ns/1ps
`include "hiccup_consts.svh"

module hiccup_overcurrent_controller
    import hiccup_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Timing configuration
    input  wire logic [7:0] switching_rate_set,
    input  wire logic       ext_sync_en,
    input  wire logic       ext_sync_pulse,
    input  wire logic [1:0] blank_sel,
    input  wire logic [1:0] dmax_sel,
    input  wire logic [1:0] phase_cfg,
    // Per-channel comparator flags
    input  wire logic [1:0] peak_current_cap_hit,
    input  wire logic [1:0] current_trip,
    input  wire logic [1:0] demand_below_skip,
    input  wire logic [1:0] ss_active,
    input  wire logic [1:0] ss_empty,
    input  wire logic [1:0] output_excess_voltage_compare,
    input  wire logic [1:0] out_in_window,
    // Power stage and soft-start control
    output logic      [1:0] gate_q,
    output logic      [1:0] demand_pulldown_q,
    output logic      [1:0] ss_discharge_q,
    output logic      [1:0] ss_restart_q,
    output logic      [1:0] soft_recover_q,
    // Status and phase output
    output logic      [1:0] hiccup_active_q,
    output logic      [1:0] power_good_q,
    output logic            clk_out_q
);

    // Three-level strap: an illegal code reads as open
    function automatic level_sel_t level_of(input logic [1:0] s);
        level_of = (s == 2'b11) ? LVL_OPEN : level_sel_t'(s);
    endfunction

    logic [7:0]  osc_div;
    logic [7:0]  div_cnt_q;
    logic [7:0]  div_cnt_d;
    logic [3:0]  sub_q;
    logic [3:0]  sub_d;
    logic        osc_tick;
    logic [1:0]  start_q;
    logic [1:0]  start_d;
    logic        clk_out_d;
    logic [11:0] period_len;
    logic [11:0] min_on_cyc;
    logic [6:0]  dmax_pct;
    logic [19:0] duty_scaled;
    logic [1:0]  sleep_w;

    // Oscillator divider and phase counter
    assign osc_div  = (switching_rate_set == 8'h00) ? 8'h01 : switching_rate_set;
    assign osc_tick = (div_cnt_q >= osc_div - 8'h01);

    always_comb
    begin
        div_cnt_d = osc_tick ? 8'h00 : div_cnt_q + 8'h01;
        sub_d     = sub_q;
        start_d   = 2'b00;
        if (ext_sync_en)
        begin
            // External edge restarts the period; counter parks at the last tick meanwhile
            if (ext_sync_pulse)
            begin
                div_cnt_d  = 8'h00;
                sub_d      = 4'h0;
                start_d[0] = 1'b1;
            end
            else if (osc_tick && (sub_q != `OSC_LAST_TICK))
            begin
                sub_d = sub_q + 4'h1;
            end
        end
        else if (osc_tick)
        begin
            sub_d      = (sub_q == `OSC_LAST_TICK) ? 4'h0 : sub_q + 4'h1;
            start_d[0] = (sub_q == `OSC_LAST_TICK);
        end
        // Second channel starts half a period later
        start_d[1] = osc_tick && (sub_q == `CH2_START_TICK) && !(ext_sync_en && ext_sync_pulse);
        clk_out_d  = (phase_cfg == PH_QUAD)
                     && (sub_q >= `CLKOUT_RISE_TICK) && (sub_q < `CLKOUT_FALL_TICK);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_cnt_q <= 8'h00;
            sub_q     <= 4'h0;
            start_q   <= 2'b00;
            clk_out_q <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            sub_q     <= sub_d;
            start_q   <= start_d;
            clk_out_q <= clk_out_d;
        end
    end

    // Bounds from the straps; period length assumes the internal rate even when synced
    assign period_len = 12'(osc_div) * 12'(`OSC_PER_PERIOD);

    always_comb
    begin
        unique case (level_of(blank_sel))
            LVL_GROUND: min_on_cyc = `MIN_ON_LO_CYC;
            LVL_OPEN:   min_on_cyc = `MIN_ON_MID_CYC;
            LVL_SUPPLY: min_on_cyc = `MIN_ON_HI_CYC;
            default:    min_on_cyc = `MIN_ON_MID_CYC;
        endcase
        unique case (level_of(dmax_sel))
            LVL_GROUND: dmax_pct = `DMAX_LO_PCT;
            LVL_OPEN:   dmax_pct = `DMAX_MID_PCT;
            LVL_SUPPLY: dmax_pct = `DMAX_HI_PCT;
            default:    dmax_pct = `DMAX_MID_PCT;
        endcase
    end

    // Compared as on_count*100 against period*percent: no divider needed
    assign duty_scaled = 20'(period_len) * 20'(dmax_pct);

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_ch
            logic [11:0] on_cnt_q;
            logic [11:0] on_cnt_d;
            logic        gate_d;
            logic        at_max;
            logic        min_done;
            logic        blocked;

            hiccup_supervisor u_hiccup (
                .clk               (clk),
                .rst               (rst),
                .period_tick       (start_q[i]),
                .clamp_reached     (peak_current_cap_hit[i]),
                .ss_active         (ss_active[i]),
                .ss_empty          (ss_empty[i]),
                .sleep_q           (sleep_w[i]),
                .demand_pulldown_q (demand_pulldown_q[i]),
                .ss_discharge_q    (ss_discharge_q[i]),
                .ss_restart_q      (ss_restart_q[i]),
                .soft_recover_q    (soft_recover_q[i])
            );

            // Judged one clock ahead so the pulse never runs past the limit
            assign at_max   = (20'(on_cnt_q + 12'h002) * `PCT_SCALE) > duty_scaled;
            assign min_done = (on_cnt_q + 12'h001) >= min_on_cyc;
            assign blocked  = sleep_w[i] || output_excess_voltage_compare[i]
                              || ((i == 1) && (phase_cfg == PH_SINGLE));

            always_comb
            begin
                gate_d   = gate_q[i];
                on_cnt_d = on_cnt_q;
                if (sleep_w[i] || output_excess_voltage_compare[i])
                begin
                    gate_d = 1'b0;
                end
                else if (start_q[i] && !gate_q[i])
                begin
                    // Light load: no pulse at all this period
                    gate_d   = !blocked && !demand_below_skip[i];
                    on_cnt_d = 12'h000;
                end
                else if (gate_q[i])
                begin
                    on_cnt_d = on_cnt_q + 12'h001;
                    // Duty limit overrides a loop still asking for more
                    if (at_max)
                    begin
                        gate_d = 1'b0;
                    end
                    else if (current_trip[i] && min_done)
                    begin
                        gate_d = 1'b0;
                    end
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    gate_q[i]          <= 1'b0;
                    on_cnt_q           <= 12'h000;
                    power_good_q[i]    <= 1'b0;
                    hiccup_active_q[i] <= 1'b0;
                end
                else
                begin
                    gate_q[i]          <= gate_d;
                    on_cnt_q           <= on_cnt_d;
                    power_good_q[i]    <= out_in_window[i] && !sleep_w[i];
                    hiccup_active_q[i] <= sleep_w[i];
                end
            end

            sleep_gate_off_a: assert property (
                @(posedge clk) disable iff (rst)
                sleep_w[i] |=> !gate_q[i])
                else $error("gate driven during hiccup sleep");

            ovp_gate_off_a: assert property (
                @(posedge clk) disable iff (rst)
                output_excess_voltage_compare[i] |=> !gate_q[i])
                else $error("gate driven during overvoltage");

            duty_bound_a: assert property (
                @(posedge clk) disable iff (rst)
                gate_q[i] && $stable(dmax_sel) && $stable(switching_rate_set)
                    |-> ((20'(on_cnt_q) + 20'h00001) * `PCT_SCALE) <= duty_scaled)
                else $error("gate pulse beyond maximum duty");

            min_on_hold_a: assert property (
                @(posedge clk) disable iff (rst)
                $rose(gate_q[i]) && (min_on_cyc > 12'h001) && !sleep_w[i]
                    && !output_excess_voltage_compare[i] && !at_max |=> gate_q[i])
                else $error("gate pulse shorter than minimum on-time");

            pulse_start_a: assert property (
                @(posedge clk) disable iff (rst)
                $rose(gate_q[i]) |-> $past(start_q[i]) && !$past(demand_below_skip[i]))
                else $error("gate pulse outside period start or during skip");

            power_good_a: assert property (
                @(posedge clk) disable iff (rst)
                power_good_q[i] |-> $past(out_in_window[i]))
                else $error("power-good high outside regulation window");
        end
    endgenerate

    clk_out_phase_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(clk_out_q) && ($past(phase_cfg, 2) == PH_QUAD) |-> ($past(sub_q) == `CLKOUT_RISE_TICK))
        else $error("clock output edge at wrong phase");

    ch2_half_period_a: assert property (
        @(posedge clk) disable iff (rst)
        start_q[1] |-> $past(osc_tick) && ($past(sub_q) == `CH2_START_TICK))
        else $error("second channel start off half period");

endmodule // hiccup_overcurrent_controller

/* File: hiccup_consts.svh */
/*
 * Numeric constants for the hiccup overcurrent controller.
 * Assumes the core clock runs at 10 MHz and that one oscillator tick is 1/12 of a period.
 */
`ifndef HICCUP_CONSTS_SVH
`define HICCUP_CONSTS_SVH

// Core clock
`define CLK_PERIOD_NS     100

// Overcurrent period timer
`define OC_LIMIT          5'h10
`define OC_LAST           5'h0F
`define GAP_CLEAR         2'h2

// Oscillator division
`define OSC_PER_PERIOD    4'hC
`define OSC_LAST_TICK     4'hB
`define CH2_START_TICK    4'h5
`define CLKOUT_RISE_TICK  4'h3
`define CLKOUT_FALL_TICK  4'h9

// Minimum on-time choices, rounded up to whole clocks
`define MIN_ON_LO_NS      120
`define MIN_ON_MID_NS     160
`define MIN_ON_HI_NS      200
`define MIN_ON_LO_CYC     12'((`MIN_ON_LO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_ON_MID_CYC    12'((`MIN_ON_MID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_ON_HI_CYC     12'((`MIN_ON_HI_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Maximum duty choices in percent
`define DMAX_LO_PCT       7'h60
`define DMAX_MID_PCT      7'h54
`define DMAX_HI_PCT       7'h4B
`define PCT_SCALE         20'h00064

`endif

/* File: hiccup_pkg.sv */
/*
 * Types shared by the hiccup overcurrent controller.
 * Assumes no surroundings beyond the design files that import it.
 */
package hiccup_pkg;

    typedef enum logic [1:0] {
        HIC_RUN   = 2'b00,
        HIC_SLEEP = 2'b01,
        HIC_RETRY = 2'b11
    } hiccup_state_t;

    typedef enum logic [1:0] {
        LVL_GROUND = 2'b00,
        LVL_OPEN   = 2'b01,
        LVL_SUPPLY = 2'b10
    } level_sel_t;

    typedef enum logic [1:0] {
        PH_SINGLE = 2'b00,
        PH_DUAL   = 2'b01,
        PH_QUAD   = 2'b10
    } phase_cfg_t;

endpackage

/* File: hiccup_supervisor.sv */
/*
 * Per-channel overcurrent period timer and hiccup sleep sequencer.
 * Assumes period_tick is a one-clock pulse once per switching period and comparator flags are synchronous.
 */
`timescale 1ns/1ps
`include "hiccup_consts.svh"

module hiccup_supervisor
    import hiccup_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Period sampling
    input  wire logic       period_tick,
    input  wire logic       clamp_reached,
    input  wire logic       ss_active,
    input  wire logic       ss_empty,
    // Sequencer outputs
    output logic            sleep_q,
    output logic            demand_pulldown_q,
    output logic            ss_discharge_q,
    output logic            ss_restart_q,
    output logic            soft_recover_q
);

    hiccup_state_t state_q;
    hiccup_state_t state_d;
    logic [4:0]    oc_cnt_q;
    logic [4:0]    oc_cnt_d;
    logic [1:0]    gap_q;
    logic [1:0]    gap_d;
    logic          recover_d;
    logic          restart_d;

    always_comb
    begin
        state_d   = state_q;
        oc_cnt_d  = oc_cnt_q;
        gap_d     = gap_q;
        recover_d = 1'b0;
        restart_d = 1'b0;
        if (period_tick)
        begin
            unique case (state_q)
                HIC_RUN:
                begin
                    if (ss_active)
                    begin
                        // Timer held empty until soft-start is done
                        oc_cnt_d = 5'h00;
                        gap_d    = 2'h0;
                    end
                    else if (clamp_reached)
                    begin
                        gap_d = 2'h0;
                        if (oc_cnt_q == `OC_LAST)
                        begin
                            oc_cnt_d = 5'h00;
                            state_d  = HIC_SLEEP;
                        end
                        else
                        begin
                            oc_cnt_d = oc_cnt_q + 5'h01;
                        end
                    end
                    else
                    begin
                        gap_d = (gap_q == `GAP_CLEAR) ? gap_q : gap_q + 2'h1;
                        if ((gap_d == `GAP_CLEAR) && (oc_cnt_q != 5'h00))
                        begin
                            oc_cnt_d  = 5'h00;
                            recover_d = 1'b1;
                        end
                    end
                end
                HIC_SLEEP:
                begin
                    if (ss_empty)
                    begin
                        state_d   = HIC_RETRY;
                        restart_d = 1'b1;
                    end
                end
                HIC_RETRY:
                begin
                    state_d = HIC_RUN;
                end
                default:
                begin
                    state_d = HIC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q           <= HIC_RUN;
            oc_cnt_q          <= 5'h00;
            gap_q             <= 2'h0;
            sleep_q           <= 1'b0;
            demand_pulldown_q <= 1'b0;
            ss_discharge_q    <= 1'b0;
            ss_restart_q      <= 1'b0;
            soft_recover_q    <= 1'b0;
        end
        else
        begin
            state_q           <= state_d;
            oc_cnt_q          <= oc_cnt_d;
            gap_q             <= gap_d;
            sleep_q           <= (state_d == HIC_SLEEP);
            demand_pulldown_q <= (state_d == HIC_SLEEP);
            ss_discharge_q    <= (state_d == HIC_SLEEP);
            ss_restart_q      <= restart_d;
            soft_recover_q    <= recover_d;
        end
    end

    sleep_after_count_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(sleep_q) |-> ($past(oc_cnt_q) == `OC_LAST) && $past(clamp_reached) && $past(period_tick))
        else $error("sleep entered without a full overcurrent run");

    discharge_in_sleep_a: assert property (
        @(posedge clk) disable iff (rst)
        ss_discharge_q && !(period_tick && ss_empty) |=> ss_discharge_q && demand_pulldown_q)
        else $error("sleep without discharge or pulldown");

    softstart_blocks_a: assert property (
        @(posedge clk) disable iff (rst)
        period_tick && ss_active && (state_q == HIC_RUN) |=> (oc_cnt_q == 5'h00) && !sleep_q)
        else $error("overcurrent timer ran during soft-start");

    gap_clears_a: assert property (
        @(posedge clk) disable iff (rst)
        period_tick && (state_q == HIC_RUN) && !ss_active && !clamp_reached && (gap_q == 2'h1)
            && (oc_cnt_q != 5'h00) |=> (oc_cnt_q == 5'h00) && soft_recover_q)
        else $error("timer not cleared after two quiet periods");

    retry_on_empty_a: assert property (
        @(posedge clk) disable iff (rst)
        period_tick && (state_q == HIC_SLEEP) && ss_empty |=> ss_restart_q && !sleep_q ##1 !ss_restart_q)
        else $error("no soft-start retry after soft-start node emptied");

endmodule // hiccup_supervisor

/* File: power_stage_model.sv */
/* Power stage and soft-start capacitor seen from the controller pins.
   Assumes the bench requests overload per channel and one clock domain. */
`timescale 1ns/1ps

module power_stage_model #(parameter int SS_FULL = 32)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Bench request and controller drive
    input  wire logic [1:0] overload,
    input  wire logic [1:0] ss_discharge,
    input  wire logic [1:0] ss_restart,
    input  wire logic [1:0] soft_recover,
    // Comparator flags
    output logic      [1:0] cap_hit,
    output logic      [1:0] ss_active,
    output logic      [1:0] ss_empty
);
    logic [7:0] lvl_q [2];

    // Capacitor fitted and charged at start, so no initial ramp
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (rst)
            begin
                lvl_q[i]     <= 8'(SS_FULL);
                ss_active[i] <= 1'b0;
                cap_hit[i]   <= 1'b0;
            end
            else
            begin
                cap_hit[i] <= overload[i];
                if (ss_restart[i] || soft_recover[i])
                begin
                    lvl_q[i]     <= 8'h00;
                    ss_active[i] <= 1'b1;
                end
                else if (ss_discharge[i] && lvl_q[i] != 8'h00)
                    lvl_q[i] <= lvl_q[i] - 8'h01;
                else if (ss_active[i])
                begin
                    if (lvl_q[i] == 8'(SS_FULL))
                        ss_active[i] <= 1'b0;
                    else
                        lvl_q[i] <= lvl_q[i] + 8'h01;
                end
            end
        end
    end

    assign ss_empty = {lvl_q[1] == 8'h00, lvl_q[0] == 8'h00};
endmodule // power_stage_model

/* File: hiccup_overcurrent_controller_tb.sv */
/* Self-checking bench for the hiccup overcurrent controller.
   Assumes rate 1, so one switching period is 12 clocks. */
`timescale 1ns/1ps

`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %s exp=%0d got=%0d", nm, exp, got); end end

module hiccup_overcurrent_controller_tb
    import hiccup_pkg::*;
;
    logic       clk, rst, sync_en, sync_p;
    logic [7:0] rate;
    logic [1:0] blank, dmax, phase, trip, skip, ovc, win, overload;
    logic [1:0] cap_hit, ss_act, ss_emp, gate, pull, dis, restart, recover, hic, pg;
    logic       ck_out;
    int         n_errors, n_tests, n, w, hi;
    int         pct [3] = '{96, 84, 75};
    int         ns  [3] = '{120, 160, 200};

    hiccup_overcurrent_controller dut (.clk(clk), .rst(rst), .switching_rate_set(rate),
        .ext_sync_en(sync_en), .ext_sync_pulse(sync_p), .blank_sel(blank), .dmax_sel(dmax),
        .phase_cfg(phase), .peak_current_cap_hit(cap_hit), .current_trip(trip),
        .demand_below_skip(skip), .ss_active(ss_act), .ss_empty(ss_emp),
        .output_excess_voltage_compare(ovc), .out_in_window(win), .gate_q(gate),
        .demand_pulldown_q(pull), .ss_discharge_q(dis), .ss_restart_q(restart),
        .soft_recover_q(recover), .hiccup_active_q(hic), .power_good_q(pg), .clk_out_q(ck_out));

    power_stage_model stage (.clk(clk), .rst(rst), .overload(overload), .ss_discharge(dis),
        .ss_restart(restart), .soft_recover(recover), .cap_hit(cap_hit), .ss_active(ss_act),
        .ss_empty(ss_emp));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task give_verdict;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    function logic sel(int k, int c);
        case (k)
            0: return gate[c];
            1: return pull[c];
            2: return restart[c];
            3: return recover[c];
            default: return ck_out;
        endcase
    endfunction

    // Bounded wait; a lapse is a mismatch and ends the run
    task wait_for(int k, int c, int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(negedge clk);
            cnt++;
        end
        while (sel(k, c) !== 1'b1 && cnt < lim);
        if (sel(k, c) !== 1'b1)
        begin
            n_errors++;
            $display("BAD wait_%0d exp=1 got=0", k);
            give_verdict();
        end
    endtask

    // Skips a pulse already running, since a strap change mid-pulse muddies it
    task pulse_width(int c, output int wd);
        int g;
        g = 0;
        while (gate[c] === 1'b1 && g < 40)
        begin
            @(negedge clk);
            g++;
        end
        wait_for(0, c, 40, g);
        wd = 0;
        while (gate[c] === 1'b1 && wd < 40)
        begin
            wd++;
            @(negedge clk);
        end
    endtask

    task no_gate(int c);
        int h;
        h = 0;
        repeat (14) @(negedge clk);
        repeat (36)
        begin
            @(negedge clk);
            if (gate[c] !== 1'b0)
                h++;
        end
        `CHECK("gate_idle", 0, h)
    endtask

    initial
    begin
        rst = 1'b1; rate = 8'h01; sync_en = 1'b0; sync_p = 1'b0; trip = 2'h0;
        blank = LVL_GROUND; dmax = LVL_GROUND; phase = PH_DUAL;
        skip = 2'h0; ovc = 2'h0; win = 2'h0; overload = 2'h0;
        n_errors = 0; n_tests = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHECK("reset_out", 0, {gate, pull, dis, hic, pg, ck_out})
        @(posedge clk) rst <= 1'b0;
        @(posedge clk) win <= 2'h3;
        repeat (3) @(negedge clk);
        `CHECK("pg_both", 3, pg)
        @(posedge clk) win <= 2'h2;
        repeat (3) @(negedge clk);
        `CHECK("pg_each", 2, pg)
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk) dmax <= 2'(i);
            for (int c = 0; c < 2; c++)
            begin
                pulse_width(c, w);
                `CHECK("duty_width", 12 * pct[i] / 100, w)
            end
        end
        @(posedge clk) dmax <= LVL_GROUND;
        trip <= 2'h3;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk) blank <= 2'(i);
            pulse_width(0, w);
            pulse_width(0, w);
            `CHECK("min_on", (ns[i] + 99) / 100, w)
        end
        @(posedge clk) trip <= 2'h0;
        skip <= 2'h1;
        no_gate(0);
        @(posedge clk) skip <= 2'h0;
        ovc <= 2'h1;
        no_gate(0);
        @(posedge clk) ovc <= 2'h0;
        pulse_width(0, w);
        `CHECK("ov_cleared", 11, w)
        @(posedge clk) phase <= PH_SINGLE;
        no_gate(1);
        @(posedge clk) phase <= PH_QUAD;
        repeat (24) @(negedge clk);
        hi = 0;
        repeat (12)
        begin
            @(negedge clk);
            if (ck_out === 1'b1)
                hi++;
        end
        `CHECK("clk_out_high", 6, hi)
        @(posedge clk) phase <= PH_DUAL;
        sync_en <= 1'b1;
        no_gate(0);
        @(posedge clk) sync_p <= 1'b1;
        @(posedge clk) sync_p <= 1'b0;
        wait_for(0, 0, 15, n);
        `CHECK("sync_start", 2, n)
        @(posedge clk) sync_en <= 1'b0;
        // Overload ends after at most fifteen sampled periods
        overload <= 2'h1;
        repeat (178) @(posedge clk);
        overload <= 2'h0;
        wait_for(3, 0, 40, n);
        `CHECK("no_sleep", 0, pull[0])
        repeat (60) @(posedge clk);
        overload <= 2'h1;
        // Window held good so a low power-good in sleep is the sleep's doing
        win <= 2'h3;
        wait_for(1, 0, 220, n);
        `CHECK("oc_periods", 1, (n >= 183 && n <= 194))
        @(negedge clk);
        `CHECK("sleep_state", 4'hC, {hic[0], dis[0], gate[0], pg[0]})
        `CHECK("other_ch", 0, pull[1])
        wait_for(2, 0, 80, n);
        `CHECK("released", 0, {pull[0], dis[0]})
        wait_for(1, 0, 400, n);
        `CHECK("ss_hold", 1, (n >= 210))
        give_verdict();
    end
endmodule // hiccup_overcurrent_controller_tb
